// file: rtcsp_top.sv
// Serial slave port with watchdog, power-down control and AXI4-Lite status
// Overview of operation
// - SCK both captures MOSI and shifts MISO
// - MOSI bytes arrive most significant bit first
// - MISO bytes leave most significant bit first
// - Chip enable low resets port, MISO off
// - Idle clock level sampled at enable rise
// - One clock per bit, whole bytes
// - Address bit 7 selects write or read
// - Address bit 5 selects clock or RAM
// - Low five bits give starting location
// - First byte after enable is address byte
// - Data bytes follow the address byte
// - MISO undriven until read byte ready
// - Location increments after every data byte
// - Increment wraps within the selected space
// - Missing enable toggles trip CPU reset
// - Power-down holds reset, clock out low
// - Supply return ends power-down, frees port
// - Restore restarts clock out from clk_src, drives supply enable, reset high
// - Status read cancels pending delayed alarm
`timescale 1ns/1ps
module rtcsp_top import rtcsp_pkg::*; #(
	parameter int WDOG_TICKS  = WDOG_TICKS_DEF,
	parameter int ALARM_DELAY = ALARM_DELAY_CYC
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire logic              chip_en,
	input  wire logic              sck,
	input  wire logic              mosi,
	output logic                   miso_o,
	output logic                   miso_oe,
	input  wire logic              system_supply_sense,
	input  wire logic              osc_tick,
	input  wire logic              clk_src,
	input  wire logic              alarm_event,
	input  wire logic              power_sense_event,
	input  wire logic              periodic_event,
	output logic                   clk_out,
	output logic                   power_supply_enable_out,
	output logic                   host_cpu_reset_out_n,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	localparam int WDW = $clog2(WDOG_TICKS + 1);
	localparam int ADW = $clog2(ALARM_DELAY + 1);

	function automatic logic [LOC_W-1:0] next_loc(input logic [LOC_W-1:0] loc);
		next_loc = {loc[LOC_W-1], loc[LOC_W-2:0] + 5'h01};
	endfunction

	logic [3:0]         pins_s;
	logic               ce_s;
	logic               sck_s;
	logic               mosi_s;
	logic               sense_s;
	logic               ce_prev_q;
	logic               sck_prev_q;
	logic               sense_prev_q;
	rtcsp_phase_t       phase_q;
	logic               cpol_q;
	logic [2:0]         bit_cnt_q;
	logic [6:0]         rx_q;
	logic               wr_q;
	logic [LOC_W-1:0]   loc_q;
	logic [7:0]         tx_q;
	logic               load_q;
	logic               stat_sel_q;
	logic [7:0]         status_q;
	logic [7:0]         ictl_q;
	logic               pd_q;
	logic               wdog_trip_q;
	logic [WDW-1:0]     wdog_cnt_q;
	logic               alm_pend_q;
	logic [ADW-1:0]     alm_cnt_q;
	logic [31:0]        ctrl_q;
	logic [7:0]         mem_rdata;
	logic               port_on;
	logic               active;
	logic               sck_lead;
	logic               sck_trail;
	logic               byte_done;
	logic [7:0]         rx_byte;
	logic               mem_wr;
	logic               mem_rd;
	logic [LOC_W-1:0]   rd_loc;
	logic               status_read;
	logic               alarm_set;
	logic               wdog_fire;
	logic               ce_toggle;
	logic               supply_back;
	logic               pd_request;
	logic               aw_take;
	logic               ar_take;

	rtcsp_sync #(
		.W (4)
	) u_sync (
		.clock  (clock),
		.rst    (rst),
		.clk_en (clk_en),
		.d_i    ({chip_en, sck, mosi, system_supply_sense}),
		.q_o    (pins_s)
	);

	assign ce_s    = pins_s[3];
	assign sck_s   = pins_s[2];
	assign mosi_s  = pins_s[1];
	assign sense_s = pins_s[0];

	always_ff @(posedge clock) begin
		if (rst) begin
			ce_prev_q    <= 1'b0;
			sck_prev_q   <= 1'b0;
			sense_prev_q <= 1'b0;
		end else if (clk_en) begin
			ce_prev_q    <= ce_s;
			sck_prev_q   <= sck_s;
			sense_prev_q <= sense_s;
		end
	end

	// Power-down disconnects the port exactly like a low chip enable
	assign port_on     = ce_s && !pd_q;
	assign active      = port_on && (phase_q != PH_IDLE);
	// Leading edge leaves the idle level, trailing edge returns to it
	assign sck_lead    = active && (sck_s != sck_prev_q) && (sck_s != cpol_q);
	assign sck_trail   = active && (sck_s != sck_prev_q) && (sck_s == cpol_q);
	assign byte_done   = sck_trail && (bit_cnt_q == 3'h7);
	assign rx_byte     = {rx_q, mosi_s};
	assign ce_toggle   = ce_s != ce_prev_q;
	assign supply_back = sense_s && !sense_prev_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			phase_q <= PH_IDLE;
			cpol_q  <= 1'b0;
		end else if (clk_en) begin
			if (!port_on) begin
				phase_q <= PH_IDLE;
			end else begin
				case (phase_q)
					PH_IDLE: begin
						phase_q <= PH_ADDR;
						cpol_q  <= sck_s;
					end
					PH_ADDR: begin
						if (byte_done) begin
							phase_q <= PH_DATA;
						end
					end
					PH_DATA: begin
						phase_q <= PH_DATA;
					end
					default: begin
						phase_q <= PH_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			bit_cnt_q <= 3'h0;
			rx_q      <= 7'h00;
		end else if (clk_en) begin
			if (!active) begin
				bit_cnt_q <= 3'h0;
				rx_q      <= 7'h00;
			end else if (sck_trail) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				rx_q      <= rx_byte[6:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_q  <= 1'b0;
			loc_q <= '0;
		end else if (clk_en) begin
			if (byte_done && phase_q == PH_ADDR) begin
				wr_q  <= rx_byte[BIT_RW];
				loc_q <= {rx_byte[BIT_SPACE], rx_byte[4:0]};
			end else if (byte_done && phase_q == PH_DATA) begin
				loc_q <= next_loc(loc_q);
			end
		end
	end

	// The status register is read-only from the serial side
	assign mem_wr = byte_done && (phase_q == PH_DATA) && wr_q && (loc_q != STATUS_LOC);
	assign mem_rd = byte_done && ((phase_q == PH_ADDR) ? !rx_byte[BIT_RW] : !wr_q);
	assign rd_loc = (phase_q == PH_ADDR) ? {rx_byte[BIT_SPACE], rx_byte[4:0]} : next_loc(loc_q);

	rtcsp_mem #(
		.AW (LOC_W),
		.DW (BYTE_W)
	) u_mem (
		.clock   (clock),
		.clk_en  (clk_en),
		.wr_en   (mem_wr),
		.wr_addr (loc_q),
		.wr_data (rx_byte),
		.rd_en   (mem_rd),
		.rd_addr (rd_loc),
		.rd_data (mem_rdata)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			load_q     <= 1'b0;
			stat_sel_q <= 1'b0;
		end else if (clk_en) begin
			load_q     <= mem_rd && port_on;
			stat_sel_q <= rd_loc == STATUS_LOC;
		end
	end

	// Next byte is fetched ahead; a burst ending just before status still clears it
	assign status_read = load_q && stat_sel_q && port_on;

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_q    <= 8'h00;
			miso_o  <= 1'b0;
			miso_oe <= 1'b0;
		end else if (clk_en) begin
			if (!port_on) begin
				miso_oe <= 1'b0;
			end else if (load_q) begin
				tx_q    <= stat_sel_q ? status_q : mem_rdata;
				miso_oe <= 1'b1;
			end else if (sck_lead && miso_oe) begin
				miso_o <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			alm_pend_q <= 1'b0;
			alm_cnt_q  <= '0;
		end else if (clk_en) begin
			// A fresh alarm wins over a status read in the same cycle
			if (alarm_event && ctrl_q[CTRL_ALM_DLY]) begin
				alm_pend_q <= 1'b1;
				alm_cnt_q  <= '0;
			end else if (status_read) begin
				alm_pend_q <= 1'b0;
				alm_cnt_q  <= '0;
			end else if (alm_pend_q) begin
				if (alm_cnt_q == ADW'(ALARM_DELAY - 1)) begin
					alm_pend_q <= 1'b0;
				end
				alm_cnt_q <= alm_cnt_q + 1'b1;
			end
		end
	end

	assign alarm_set = ctrl_q[CTRL_ALM_DLY] ? (alm_pend_q && alm_cnt_q == ADW'(ALARM_DELAY - 1) && !status_read)
	                                        : alarm_event;

	// Set wins over the clear that a status read makes
	always_ff @(posedge clock) begin
		if (rst) begin
			status_q <= STATUS_RST;
		end else if (clk_en) begin
			status_q <= (status_read ? (status_q & STATUS_KEEP) : status_q)
			          | {1'b0, wdog_fire, 1'b0, 1'b0,
			             alarm_set | power_sense_event | periodic_event,
			             power_sense_event, alarm_set, periodic_event};
		end
	end

	assign pd_request = mem_wr && (loc_q == ICTL_LOC) && rx_byte[ICTL_PDOWN];

	always_ff @(posedge clock) begin
		if (rst) begin
			ictl_q <= ICTL_RST;
		end else if (clk_en) begin
			if (mem_wr && loc_q == ICTL_LOC) begin
				ictl_q <= rx_byte;
			end else if (pd_q && supply_back) begin
				ictl_q[ICTL_PDOWN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pd_q                    <= 1'b0;
			power_supply_enable_out <= 1'b1;
		end else if (clk_en) begin
			if (pd_request) begin
				pd_q                    <= 1'b1;
				power_supply_enable_out <= 1'b0;
			end else if (pd_q && supply_back) begin
				pd_q                    <= 1'b0;
				power_supply_enable_out <= 1'b1;
			end
		end
	end

	// Tick count between enable toggles; tripped state holds until a toggle or until ictl_q[ICTL_WDOG] clears
	assign wdog_fire = ictl_q[ICTL_WDOG] && !wdog_trip_q && osc_tick && !ce_toggle
	                && (wdog_cnt_q == WDW'(WDOG_TICKS - 1));

	always_ff @(posedge clock) begin
		if (rst) begin
			wdog_cnt_q  <= '0;
			wdog_trip_q <= 1'b0;
		end else if (clk_en) begin
			if (!ictl_q[ICTL_WDOG] || ce_toggle) begin
				wdog_cnt_q  <= '0;
				wdog_trip_q <= 1'b0;
			end else if (wdog_fire) begin
				wdog_trip_q <= 1'b1;
			end else if (osc_tick && !wdog_trip_q) begin
				wdog_cnt_q <= wdog_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			host_cpu_reset_out_n <= 1'b1;
			clk_out              <= 1'b0;
		end else if (clk_en) begin
			host_cpu_reset_out_n <= !(pd_q || wdog_trip_q);
			clk_out              <= clk_src && !pd_q;
		end
	end

	// Write address and data are taken together; no write buffering needed
	assign aw_take       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = aw_take;
	assign s_axi_wready  = aw_take;
	assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q       <= CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
		end else if (clk_en) begin
			if (aw_take) begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == REG_CTRL) begin
					s_axi_bresp <= AXI_OKAY;
					if (s_axi_wstrb[0]) begin
						ctrl_q[CTRL_ALM_DLY] <= s_axi_wdata[CTRL_ALM_DLY];
					end
				end else begin
					s_axi_bresp <= AXI_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= AXI_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				if (s_axi_araddr == REG_CTRL) begin
					s_axi_rdata <= ctrl_q;
					s_axi_rresp <= AXI_OKAY;
				end else if (s_axi_araddr == REG_STAT) begin
					s_axi_rdata <= {8'h00, status_q, ictl_q, loc_q, wr_q, cpol_q};
					s_axi_rresp <= AXI_OKAY;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= AXI_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// file: rtcsp_pkg.sv
// Shared constants and types for the serial real-time-clock port
package rtcsp_pkg;
	localparam int          BYTE_W         = 8;
	localparam int          LOC_W          = 6;
	localparam int          BIT_RW         = 7;
	localparam int          BIT_SPACE      = 5;
	localparam logic [5:0]  STATUS_LOC     = 6'h30;
	localparam logic [5:0]  ICTL_LOC       = 6'h32;
	localparam int          ICTL_WDOG      = 7;
	localparam int          ICTL_PDOWN     = 6;
	localparam int          ST_WDOG        = 6;
	localparam int          ST_INT         = 3;
	localparam int          ST_PSENSE      = 2;
	localparam int          ST_ALARM       = 1;
	localparam int          ST_CLOCK       = 0;
	localparam logic [7:0]  STATUS_RST     = 8'h10;
	localparam logic [7:0]  STATUS_KEEP    = 8'h04;
	localparam logic [7:0]  ICTL_RST       = 8'h00;
	localparam int          CLK_PERIOD_NS  = 5;
	localparam int          ALARM_DELAY_NS = 8300000;
	localparam int          ALARM_DELAY_CYC = ALARM_DELAY_NS / CLK_PERIOD_NS;
	localparam int          WDOG_TICKS_DEF = 16;
	localparam int          AXI_AW         = 4;
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_STAT       = 4'h4;
	localparam int          CTRL_ALM_DLY   = 0;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [1:0]  AXI_OKAY       = 2'h0;
	localparam logic [1:0]  AXI_SLVERR     = 2'h2;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_ADDR = 3'b010,
		PH_DATA = 3'b100
	} rtcsp_phase_t;
endpackage

// file: rtcsp_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module rtcsp_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= '0;
			q_o    <= '0;
		end else if (clk_en) begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// file: rtcsp_mem.sv
// Byte store for RAM and clock register spaces, registered read
`timescale 1ns/1ps
module rtcsp_mem #(
	parameter int AW = 6,
	parameter int DW = 8
) (
	input  wire logic          clock,
	input  wire logic          clk_en,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];

	always_ff @(posedge clock) begin
		if (clk_en && wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Contents are not reset, as in a real byte store
	always_ff @(posedge clock) begin
		if (clk_en && rd_en) begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule

// file: rtcsp_chk.sv
// Port checker for the serial clock port
`timescale 1ns/1ps
module rtcsp_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        chip_en,
	input wire logic        miso_oe,
	input wire logic        system_supply_sense,
	input wire logic        clk_src,
	input wire logic        clk_out,
	input wire logic        power_supply_enable_out,
	input wire logic        host_cpu_reset_out_n,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Six cycles cover the pin synchroniser
	property p_oe_off; !chip_en [*6] |-> !miso_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso on while idle");
	property p_oe_late; $rose(chip_en) |=> !miso_oe [*8]; endproperty
	a_oe_late: assert property (p_oe_late) else $error("miso on before byte");
	property p_pd_rst; !power_supply_enable_out && !$past(power_supply_enable_out) |-> !host_cpu_reset_out_n; endproperty
	a_pd_rst: assert property (p_pd_rst) else $error("reset free in power-down");
	property p_pd_clk; !$past(power_supply_enable_out) |-> !clk_out; endproperty
	a_pd_clk: assert property (p_pd_clk) else $error("clock out in power-down");
	property p_sense; $rose(system_supply_sense) && !power_supply_enable_out |-> ##[1:8] power_supply_enable_out; endproperty
	a_sense: assert property (p_sense) else $error("no exit on supply");
	property p_clk; !$past(rst) && $past(power_supply_enable_out) |-> clk_out == $past(clk_src); endproperty
	a_clk: assert property (p_clk) else $error("clock out wrong");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule

// file: rtcsp_host.sv
// Serial bus master model standing in for the host processor
`timescale 1ns/1ps
module rtcsp_host (
	input  wire logic       clock,
	input  wire logic       miso_o,
	input  wire logic       miso_oe,
	output logic            chip_en,
	output logic            sck,
	output logic            mosi,
	output logic [7:0]      rx_byte,
	output logic            rx_stb
);
	logic [7:0] tx [5];

	initial begin
		{chip_en, sck, mosi, rx_stb, rx_byte} = 12'h0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Half link period is 16 clocks; clock idles outside frames
	task automatic frame(input logic cpol, input int n);
		logic [7:0] r;
		sck <= cpol;
		wt(16);
		chip_en <= 1'b1;
		wt(16);
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				sck <= ~cpol;
				mosi <= tx[i][b];
				wt(16);
				sck <= cpol;
				r[b] = miso_oe ? miso_o : 1'bx;
				wt(16);
			end
			if (i > 0 && !tx[0][7]) begin
				rx_byte <= r;
				rx_stb <= 1'b1;
				wt(1);
				rx_stb <= 1'b0;
			end
		end
		chip_en <= 1'b0;
		mosi <= ~mosi; // No stale bit once released
		wt(16);
	endtask
endmodule

// file: rtcsp_tb.sv
// Self-checking bench for the serial clock port
`timescale 1ns/1ps
module testbench;
	import rtcsp_pkg::*;
	logic        clock, rst, clk_en, chip_en, sck, mosi, miso_o, miso_oe, rx_stb;
	logic        system_supply_sense, osc_tick, clk_src, clk_out;
	logic        power_supply_enable_out, host_cpu_reset_out_n;
	logic        alarm_event, power_sense_event, periodic_event;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  rx_byte;
	logic [2:0]  ev;
	logic [67:0] exp_q[$];
	int          errors, cmp_count;

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	rtcsp_top #(.WDOG_TICKS(4), .ALARM_DELAY(2000)) u_dut (.clock, .rst, .clk_en, .chip_en, .sck, .mosi,
		.miso_o, .miso_oe, .system_supply_sense, .osc_tick, .clk_src, .alarm_event, .power_sense_event,
		.periodic_event, .clk_out, .power_supply_enable_out, .host_cpu_reset_out_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rtcsp_host u_host (.clock, .miso_o, .miso_oe, .chip_en, .sck, .mosi, .rx_byte, .rx_stb);
	assign {alarm_event, power_sense_event, periodic_event} = ev;

	always @(posedge clock) begin
		clk_src <= ~clk_src;
		if (rx_stb === 1'b1)
			pop({26'h0, rx_byte});
		if (s_axi_rvalid === 1'b1 && s_axi_rready)
			pop({s_axi_rresp, s_axi_rdata});
	end

	task automatic print_verdict;
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Upper half of a note is the mask, lower half the value
	task automatic chk(input logic [33:0] got, input logic [67:0] e);
		cmp_count++;
		if ((got & e[67:34]) !== (e[33:0] & e[67:34])) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got & e[67:34], e[33:0] & e[67:34]);
		end
	endtask

	task automatic pop(input logic [33:0] got);
		chk(got, exp_q.size() > 0 ? exp_q.pop_front() : {34'h3_ffff_ffff, 34'hz});
	endtask

	task automatic lv(input logic [1:0] e);
		chk({32'h0, power_supply_enable_out, host_cpu_reset_out_n}, {34'h3, 32'h0, e});
	endtask

	task automatic tmo(inout int n);
		@(posedge clock);
		n++;
		if (n > 5000) begin
			errors++;
			print_verdict;
		end
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do tmo(n); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1) tmo(n);
		s_axi_bready <= 1'b0;
		chk({s_axi_bresp, 32'h0}, {2'h3, 32'h0, r, 32'h0});
		// Let an edge pass so a following call never re-raises bready in this step
		@(posedge clock);
	endtask

	task automatic axr(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
		int n;
		n = 0;
		exp_q.push_back({m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do tmo(n); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do tmo(n); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic cpol, input logic [31:0] d, input int n);
		u_host.tx[0] = a;
		for (int i = 0; i < 4; i++)
			u_host.tx[i + 1] = d[31 - 8 * i -: 8];
		u_host.frame(cpol, n + 1);
	endtask

	task automatic rd(input logic [7:0] a, input logic cpol, input logic [31:0] d, input int n);
		for (int i = 0; i < n; i++)
			exp_q.push_back({34'hff, 26'h0, d[31 - 8 * i -: 8]});
		wr(a & 8'h7f, cpol, 32'h0, n);
	endtask

	task automatic pulse(input logic [2:0] k);
		ev <= k;
		@(posedge clock);
		ev <= 3'h0;
		repeat (4) @(posedge clock);
	endtask

	task automatic tk(input int n);
		repeat (n) begin
			osc_tick <= 1'b1;
			@(posedge clock);
			osc_tick <= 1'b0;
			@(posedge clock);
		end
	endtask

	initial begin
		rnd = $urandom(32'hf1e755d6);
		{rst, clk_en, system_supply_sense, osc_tick, clk_src, ev} = {3'b111, 5'h0};
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		errors = 0;
		cmp_count = 0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
		lv(2'h3);
		axr(REG_STAT, {AXI_OKAY, 8'h0, STATUS_RST, ICTL_RST, 8'h0}, 34'h0_00ff_ff00);
		axr(4'h8, {AXI_SLVERR, 32'h0}, '1);
		axw(4'hc, 32'h1, AXI_SLVERR);
		axw(REG_STAT, 32'h1, AXI_SLVERR);
		axw(REG_CTRL, 32'h1, AXI_OKAY);
		axr(REG_CTRL, {AXI_OKAY, 32'h1}, '1);
		axw(REG_CTRL, CTRL_RST, AXI_OKAY);
		rnd = $urandom;
		wr(8'h9e, 1'b0, rnd, 4);
		rd(8'h1e, 1'b1, rnd, 4);
		rd(8'h00, 1'b0, rnd << 16, 1);
		rnd = $urandom;
		wr(8'hbe, 1'b1, rnd, 4);
		rd(8'h20, 1'b0, rnd << 16, 2);
		rd(8'h30, 1'b0, {STATUS_RST, 24'h0}, 1);
		// Events in turn: periodic, power sense, alarm, none
		for (int i = 0; i < 4; i++) begin
			if (i < 3)
				pulse(3'h1 << i);
			rd(8'h30, 1'b0, {32'h090c0e04 << (8 * i)}, 1);
		end
		axw(REG_CTRL, 32'h1, AXI_OKAY);
		pulse(3'h4);
		repeat (2500) @(posedge clock);
		rd(8'h30, 1'b0, 32'h0e00_0000, 1);
		pulse(3'h4);
		rd(8'h30, 1'b0, 32'h0400_0000, 1);
		repeat (2500) @(posedge clock);
		rd(8'h30, 1'b0, 32'h0400_0000, 1);
		system_supply_sense <= 1'b0;
		wr(8'hb2, 1'b0, 32'h4000_0000, 1);
		repeat (8) @(posedge clock);
		lv(2'h0);
		rd(8'h20, 1'b1, 32'hxx00_0000, 1);
		system_supply_sense <= 1'b1;
		repeat (8) @(posedge clock);
		lv(2'h3);
		axr(REG_STAT, {AXI_OKAY, 16'h0, ICTL_RST, 8'h0}, 34'hff00);
		rd(8'h20, 1'b1, rnd << 16, 2);
		wr(8'hb2, 1'b0, 32'h8000_0000, 1);
		repeat (3) begin
			tk(3);
			u_host.frame(1'b0, 0);
		end
		lv(2'h3);
		tk(6);
		repeat (4) @(posedge clock);
		lv(2'h2);
		axr(REG_STAT, {AXI_OKAY, 32'h0040_0000}, 34'h40_0000);
		u_host.frame(1'b0, 0);
		lv(2'h3);
		wr(8'hb2, 1'b0, 32'h0, 1);
		print_verdict;
	end
endmodule

bind rtcsp_top rtcsp_chk u_chk (.clock, .rst, .chip_en, .miso_oe, .system_supply_sense, .clk_src, .clk_out,
	.power_supply_enable_out, .host_cpu_reset_out_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
